/* rtl/rdh_host_port.sv */
// Serial-bus register port, data-available logic, resets and pause timing
//
// Contract
// - Pause ends only after audio stays above threshold for 5 ms.
// - Pause is a digital pin, low while a pause is detected.
// - Four pause thresholds chosen by the two threshold bits.
// - Pause minimum time set by oscillator select and two time bits.
// - Crystal n times 4.332 MHz, n 1..4, divided to the core tick.
// - Internal reset on power-up, supply drop, or oscillator below 400 Hz.
// - Internal reset clears bus registers and slave logic, releases data line.
// - Reset sets a reset-seen flag; reading the status byte clears it.
// - Write registers except oscillator select take defaults at reset; here oscillator select also resets, to n = 1.
// - Serial slave for fast mode 400 kbit/s and standard rates.
// - Clock line is input only; data moves in acknowledged bytes.
// - Data-available output goes low when new results are ready.
// - Three write-only control bytes and seven read-only result bytes.
// - Decoder refreshes results and latches control settings per block.
// - Separate read and write pointers with enables from decoder or bus.
// - Pointer starts at first byte and advances by one per byte.
// - Reads return status, last, previous, error, quality in order.
// - Data-available returns high after 10 ms or once status is read.
// - Overflow freezes results until the host reads it clear.
module rdh_host_port
   import rdh_pkg::*;
#(
   parameter logic [6:0] SLAVE_ADDR = 7'h11,
   parameter int NOPAUSE_CNT = NOPAUSE_TICKS,
   parameter int DAV_CNT = DAV_HOLD_TICKS,
   parameter int PMIN0_CNT = PAUSE_MIN_0_TICKS,
   parameter int PMIN1_CNT = PAUSE_MIN_1_TICKS,
   parameter int PMIN2_CNT = PAUSE_MIN_2_TICKS,
   parameter int PMIN3_CNT = PAUSE_MIN_3_TICKS,
   parameter int STALL_CNT = OSC_STALL_CYCLES
)(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic xtalClk,
   input wire logic supplyLow,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   input wire logic [3:0] audioAbove,
   input wire logic resultWe,
   input wire rdh_result_s resultIn,
   input wire logic latchReq,
   output rdh_ctrl_s ctrlOut,
   output logic resultsReadyN,
   output logic pauseOutN
);

   typedef enum {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR_DATA, ST_WR_ACK,
                 ST_RD_DATA, ST_RD_ACK} rdh_bus_e;

   rdh_bus_e state_reg;
   logic [6:0] pinMeta, pinSync;
   logic sclPrev, sdaPrev;
   logic sclS, sdaS, supplyS;
   logic [3:0] aboveS;
   logic sclRise, sclFall, startDet, stopDet;
   logic [2:0] tickSync;
   logic sysTick;
   logic tickToggle;
   logic [17:0] stallCnt;
   logic [4:0] divHold;
   logic divRst_reg;
   logic oscFail_reg, intRst;
   rdh_sel_t oscSel_reg;
   logic [7:0] wrRegs [3];
   rdh_result_s result_reg;
   logic resetSeen_reg, overflow_reg, pending_reg;
   logic [15:0] davCnt;
   logic [3:0] bitCnt;
   logic [7:0] shift_reg;
   logic rwBit_reg;
   logic [1:0] wrPtr;
   logic [2:0] rdPtr;
   logic [7:0] rdByte;
   logic byteDone, readDone, statusRead, lastRead, accept;
   logic quietBelow;
   logic [19:0] quietCnt, loudCnt;
   logic [19:0] pauseMin;

   // ----------------------------------------------------------------
   // Pin synchronisers and bus edge detection
   // ----------------------------------------------------------------
   // Supply, audio and bus pins pass two flops; only the second stage is looked at
   always_ff @(posedge sys_clk) begin
      pinMeta <= {supplyLow, audioAbove, sclIn, sdaIn};
      pinSync <= pinMeta;
      sclPrev <= sclS;
      sdaPrev <= sdaS;
   end

   assign {supplyS, aboveS, sclS, sdaS} = pinSync;
   // Clock line is sampled only, never driven
   assign sclRise = sclS & ~sclPrev;
   assign sclFall = ~sclS & sclPrev;
   assign startDet = sclS & sclPrev & sdaPrev & ~sdaS;
   assign stopDet = sclS & sclPrev & ~sdaPrev & sdaS;

   // ----------------------------------------------------------------
   // Core tick from the crystal domain and oscillator watchdog
   // ----------------------------------------------------------------
   // Stretched reset, so the slower crystal domain is sure to catch it
   always_ff @(posedge sys_clk) begin
      divHold <= reset ? DIV_RST_CYCLES : divHold - {4'h0, divHold != 5'h00};
      divRst_reg <= reset || divHold != 5'h00;
   end

   rdh_clk_div u_div (
      .xtalClk(xtalClk),
      .rstReq(divRst_reg),
      .oscSel(oscSel_reg),
      .tickToggle(tickToggle)
   );

   // Toggle crossing: each change of the toggle is one core tick
   always_ff @(posedge sys_clk) begin
      tickSync <= {tickSync[1:0], tickToggle};
   end

   assign sysTick = tickSync[2] ^ tickSync[1];

   // Watchdog runs on the pin reset only, so its own reset cannot latch up
   always_ff @(posedge sys_clk) begin
      if (reset || divRst_reg || sysTick) begin
         stallCnt <= 18'h0;
         oscFail_reg <= 1'b0;
      end else if (stallCnt >= 18'(STALL_CNT - 1)) begin
         oscFail_reg <= 1'b1;
      end else begin
         stallCnt <= stallCnt + 18'h1;
      end
   end

   // Internal reset from every source
   assign intRst = reset | supplyS | oscFail_reg;

   // ----------------------------------------------------------------
   // Serial slave state machine
   // ----------------------------------------------------------------
   assign byteDone = sclFall && (bitCnt == 4'h8);
   assign readDone = (state_reg == ST_RD_DATA) && byteDone;
   assign statusRead = readDone && (rdPtr == RD_STATUS);
   assign lastRead = readDone && (rdPtr == RD_LAST);

   // Read order: status, last high/low, previous high/low, error, quality
   always_comb begin
      unique case (rdPtr)
         3'h0: begin
            rdByte = result_reg.status;
            rdByte[RESET_SEEN_FLAG_BIT] = resetSeen_reg;
            rdByte[RESULT_OVERFLOW_FLAG_BIT] = overflow_reg;
         end
         3'h1: rdByte = result_reg.lastHi;
         3'h2: rdByte = result_reg.lastLo;
         3'h3: rdByte = result_reg.prevHi;
         3'h4: rdByte = result_reg.prevLo;
         3'h5: rdByte = result_reg.errStat;
         3'h6: rdByte = result_reg.quality;
         default: rdByte = 8'hff;
      endcase
   end

   // Byte-wide shifting with acknowledges, usable at any rate to 400 kbit/s
   always_ff @(posedge sys_clk) begin
      if (intRst) begin
         state_reg <= ST_IDLE;
         bitCnt <= 4'h0;
         shift_reg <= 8'h00;
         rwBit_reg <= 1'b0;
         sdaOe <= 1'b0; // Data line released during reset
      end else if (startDet) begin
         state_reg <= ST_ADDR;
         bitCnt <= 4'h0;
         sdaOe <= 1'b0;
      end else if (stopDet) begin
         state_reg <= ST_IDLE;
         sdaOe <= 1'b0;
      end else begin
         unique case (state_reg)
            ST_IDLE: sdaOe <= 1'b0;
            ST_ADDR, ST_WR_DATA: begin
               if (sclRise) begin
                  shift_reg <= {shift_reg[6:0], sdaS};
                  bitCnt <= bitCnt + 4'h1;
               end else if (byteDone) begin
                  bitCnt <= 4'h0;
                  if (state_reg == ST_ADDR) begin
                     if (shift_reg[7:1] == SLAVE_ADDR) begin
                        rwBit_reg <= shift_reg[0];
                        sdaOe <= 1'b1;
                        state_reg <= ST_ADDR_ACK;
                     end else begin
                        state_reg <= ST_IDLE;
                     end
                  end else begin
                     // Bytes past the third control byte are refused
                     sdaOe <= (wrPtr <= WR_LAST);
                     state_reg <= ST_WR_ACK;
                  end
               end
            end
            ST_ADDR_ACK, ST_WR_ACK: begin
               if (sclFall) begin
                  if (state_reg == ST_ADDR_ACK && rwBit_reg) begin
                     shift_reg <= {rdByte[6:0], 1'b0};
                     sdaOe <= ~rdByte[7];
                     state_reg <= ST_RD_DATA;
                  end else begin
                     sdaOe <= 1'b0;
                     state_reg <= ST_WR_DATA;
                  end
               end
            end
            ST_RD_DATA: begin
               if (sclRise) begin
                  bitCnt <= bitCnt + 4'h1;
               end else if (byteDone) begin
                  bitCnt <= 4'h0;
                  sdaOe <= 1'b0;
                  state_reg <= ST_RD_ACK;
               end else if (sclFall) begin
                  sdaOe <= ~shift_reg[7];
                  shift_reg <= {shift_reg[6:0], 1'b0};
               end
            end
            ST_RD_ACK: begin
               if (sclRise) begin
                  rwBit_reg <= ~sdaS; // Master acknowledge asks for more
               end else if (sclFall) begin
                  if (rwBit_reg) begin
                     shift_reg <= {rdByte[6:0], 1'b0};
                     sdaOe <= ~rdByte[7];
                     state_reg <= ST_RD_DATA;
                  end else begin
                     state_reg <= ST_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // Open drain: the line is only ever pulled low
   always_ff @(posedge sys_clk) begin
      sdaOut <= 1'b0;
   end

   // ----------------------------------------------------------------
   // Bus pointers
   // ----------------------------------------------------------------
   // Separate read and write pointers, reloaded on each start
   always_ff @(posedge sys_clk) begin
      if (intRst || startDet) begin
         wrPtr <= WR_MODE;
         rdPtr <= RD_STATUS;
      end else if (state_reg == ST_WR_DATA && byteDone && wrPtr <= WR_LAST) begin
         wrPtr <= wrPtr + 2'h1;
      end else if (readDone && rdPtr <= RD_LAST) begin
         rdPtr <= rdPtr + 3'h1;
      end
   end

   // ----------------------------------------------------------------
   // Control registers and decoder latch
   // ----------------------------------------------------------------
   // Host sends mode, pause level, pause time in that order
   always_ff @(posedge sys_clk) begin
      if (intRst) begin
         wrRegs[WR_MODE] <= MODE_RST;
         wrRegs[WR_PAUSE] <= PAUSE_RST;
         wrRegs[WR_PTOSC] <= PTOSC_RST;
      end else if (state_reg == ST_WR_DATA && byteDone && wrPtr <= WR_LAST) begin
         wrRegs[wrPtr] <= shift_reg;
      end
   end

   // Oscillator select taken only when the byte carries the select flag
   // It falls back to n = 1 and relies on the host rewriting it
   always_ff @(posedge sys_clk) begin
      if (intRst) begin
         oscSel_reg <= OSC_SEL_RST;
      end else if (state_reg == ST_WR_DATA && byteDone && wrPtr == WR_PTOSC
                   && shift_reg[OSC_SELECT_ENABLE_BIT]) begin
         oscSel_reg <= shift_reg[PTF_LSB +: 2];
      end
   end

   // Decoder latches settings on its own strobe, so bus writes land atomically
   always_ff @(posedge sys_clk) begin
      if (intRst) begin
         ctrlOut <= '{MODE_RST, PAUSE_RST, PTOSC_RST};
      end else if (latchReq) begin
         ctrlOut <= '{wrRegs[WR_MODE], wrRegs[WR_PAUSE], wrRegs[WR_PTOSC]};
      end
   end

   // ----------------------------------------------------------------
   // Result registers, flags and data-available
   // ----------------------------------------------------------------
   // New block ignored while data-available is low, the last block is not fully read, or overflow is flagged
   assign accept = resultWe && !overflow_reg && resultsReadyN && !pending_reg;

   always_ff @(posedge sys_clk) begin
      if (intRst) begin
         result_reg <= '0;
      end else if (accept) begin
         result_reg <= resultIn;
      end
   end

   // Set wins over the clear from a status read
   always_ff @(posedge sys_clk) begin
      if (intRst) begin
         resetSeen_reg <= 1'b1;
         overflow_reg <= 1'b0;
         pending_reg <= 1'b0;
      end else begin
         if (statusRead) begin
            resetSeen_reg <= 1'b0;
         end
         if (resultWe && resultsReadyN && pending_reg) begin
            overflow_reg <= 1'b1;
         end else if (statusRead) begin
            overflow_reg <= 1'b0;
         end
         if (accept) begin
            pending_reg <= 1'b1;
         end else if (lastRead) begin
            pending_reg <= 1'b0;
         end
      end
   end

   // Low on new results or after reset; high on timeout or status read
   always_ff @(posedge sys_clk) begin
      if (intRst) begin
         resultsReadyN <= 1'b0;
         davCnt <= 16'h0;
      end else if (accept) begin
         resultsReadyN <= 1'b0;
         davCnt <= 16'h0;
      end else if (statusRead) begin
         resultsReadyN <= 1'b1;
      end else if (!resultsReadyN && sysTick) begin
         if (davCnt >= 16'(DAV_CNT - 1)) begin
            resultsReadyN <= 1'b1;
         end else begin
            davCnt <= davCnt + 16'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Pause detector timing
   // ----------------------------------------------------------------
   // Threshold chosen from four comparator levels 4 dB apart
   assign quietBelow = ~aboveS[ctrlOut.pauseFly[PL_LSB +: 2]];

   // Minimum pause time always follows the two time bits, whether or not the select flag is set
   always_comb begin
      unique case (ctrlOut.ptOsc[PTF_LSB +: 2])
         2'h0: pauseMin = 20'(PMIN0_CNT);
         2'h1: pauseMin = 20'(PMIN1_CNT);
         2'h2: pauseMin = 20'(PMIN2_CNT);
         2'h3: pauseMin = 20'(PMIN3_CNT);
      endcase
   end

   // Counts core ticks; loud bursts shorter than 5 ms keep the pause
   always_ff @(posedge sys_clk) begin
      if (intRst) begin
         quietCnt <= 20'h0;
         loudCnt <= 20'h0;
         pauseOutN <= 1'b1;
      end else if (sysTick) begin
         if (quietBelow) begin
            loudCnt <= 20'h0;
            if (quietCnt >= pauseMin - 20'h1) begin
               pauseOutN <= 1'b0;
            end else begin
               quietCnt <= quietCnt + 20'h1;
            end
         end else begin
            quietCnt <= 20'h0;
            if (loudCnt >= 20'(NOPAUSE_CNT - 1)) begin
               pauseOutN <= 1'b1;
            end else begin
               loudCnt <= loudCnt + 20'h1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (intRst);

   pause_release_a: assert property (
      $rose(pauseOutN) |-> $past(loudCnt) >= 20'(NOPAUSE_CNT - 1))
      else $error("pause ended before loud time elapsed");

   pause_enter_a: assert property (
      $fell(pauseOutN) |-> $past(quietCnt) >= $past(pauseMin) - 20'h1)
      else $error("pause declared before minimum time");

   results_ready_a: assert property (
      accept |=> !resultsReadyN && pending_reg)
      else $error("accepted block did not raise data-available");

   ready_clear_a: assert property (
      statusRead && !accept |=> resultsReadyN)
      else $error("status read left data-available low");

   reset_seen_a: assert property (
      statusRead |=> !resetSeen_reg)
      else $error("reset-seen flag survived status read");

   overflow_freeze_a: assert property (
      overflow_reg |=> $stable(result_reg))
      else $error("results changed while overflow flagged");

   ptr_restart_a: assert property (
      startDet |=> wrPtr == WR_MODE && rdPtr == RD_STATUS)
      else $error("pointers not restarted on start");

   wr_advance_a: assert property (
      state_reg == ST_WR_DATA && byteDone && wrPtr <= WR_LAST && !startDet
      |=> wrPtr == $past(wrPtr) + 2'h1)
      else $error("write pointer did not advance");

   addr_ack_a: assert property (
      state_reg == ST_ADDR && byteDone && shift_reg[7:1] == SLAVE_ADDR
      && !startDet && !stopDet |=> sdaOe ##0 state_reg == ST_ADDR_ACK)
      else $error("own address not acknowledged");

endmodule // rdh_host_port

/* rtl/rdh_pkg.sv */
// Constants and carriers shared by the radio data host register port
package rdh_pkg;

   // ----------------------------------------------------------------
   // Clocks and times
   // ----------------------------------------------------------------
   localparam int SYS_CLK_HZ = 50_000_000;
   localparam int CORE_TICK_KHZ = 4332;
   localparam int OSC_MIN_HZ = 400;
   localparam int NOPAUSE_US = 5000;
   localparam int DAV_HOLD_US = 10000;
   localparam int PAUSE_MIN_0_TENTH_MS = 202;
   localparam int PAUSE_MIN_1_TENTH_MS = 404;
   localparam int PAUSE_MIN_2_TENTH_MS = 808;
   localparam int PAUSE_MIN_3_TENTH_MS = 1617;
   localparam logic [4:0] DIV_RST_CYCLES = 5'h1f;

   // Least times round up, the hold-off timeout rounds down
   localparam int NOPAUSE_TICKS = (NOPAUSE_US * CORE_TICK_KHZ + 999) / 1000;
   localparam int DAV_HOLD_TICKS = (DAV_HOLD_US * CORE_TICK_KHZ) / 1000;
   localparam int PAUSE_MIN_0_TICKS = (PAUSE_MIN_0_TENTH_MS * CORE_TICK_KHZ + 9) / 10;
   localparam int PAUSE_MIN_1_TICKS = (PAUSE_MIN_1_TENTH_MS * CORE_TICK_KHZ + 9) / 10;
   localparam int PAUSE_MIN_2_TICKS = (PAUSE_MIN_2_TENTH_MS * CORE_TICK_KHZ + 9) / 10;
   localparam int PAUSE_MIN_3_TICKS = (PAUSE_MIN_3_TENTH_MS * CORE_TICK_KHZ + 9) / 10;
   localparam int OSC_STALL_CYCLES = SYS_CLK_HZ / OSC_MIN_HZ;

   // ----------------------------------------------------------------
   // Register indices
   // ----------------------------------------------------------------
   localparam logic [1:0] WR_MODE = 2'h0;
   localparam logic [1:0] WR_PAUSE = 2'h1;
   localparam logic [1:0] WR_PTOSC = 2'h2;
   localparam logic [1:0] WR_LAST = 2'h2;
   localparam logic [2:0] RD_STATUS = 3'h0;
   localparam logic [2:0] RD_LAST = 3'h6;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int PL_LSB = 6;
   localparam int OSC_SELECT_ENABLE_BIT = 5;
   localparam int PTF_LSB = 6;
   localparam int RESET_SEEN_FLAG_BIT = 1;
   localparam int RESULT_OVERFLOW_FLAG_BIT = 0;
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [7:0] PAUSE_RST = 8'h00;
   localparam logic [7:0] PTOSC_RST = 8'h00;
   localparam logic [1:0] OSC_SEL_RST = 2'h0;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef logic [1:0] rdh_sel_t;

   typedef struct packed {
      logic [7:0] status;
      logic [7:0] lastHi;
      logic [7:0] lastLo;
      logic [7:0] prevHi;
      logic [7:0] prevLo;
      logic [7:0] errStat;
      logic [7:0] quality;
   } rdh_result_s;

   typedef struct packed {
      logic [7:0] mode;
      logic [7:0] pauseFly;
      logic [7:0] ptOsc;
   } rdh_ctrl_s;

endpackage

/* rtl/rdh_clk_div.sv */
// Crystal-domain divider making the internal core tick as a toggle
module rdh_clk_div
   import rdh_pkg::*;
(
   input wire logic xtalClk,
   input wire logic rstReq,
   input wire rdh_sel_t oscSel,
   output logic tickToggle
);

   logic [1:0] rstSync;
   rdh_sel_t selMeta;
   rdh_sel_t selSync;
   rdh_sel_t divCnt;

   // ----------------------------------------------------------------
   // Crossings into the crystal domain
   // ----------------------------------------------------------------
   // Selector is quasi-static, written only at reset or over the serial bus
   always_ff @(posedge xtalClk) begin
      rstSync <= {rstSync[0], rstReq};
      selMeta <= oscSel;
      selSync <= selMeta;
   end

   // ----------------------------------------------------------------
   // Divide by n; each toggle is one core tick
   // ----------------------------------------------------------------
   always_ff @(posedge xtalClk) begin
      if (rstSync[1]) begin
         divCnt <= 2'h0;
         tickToggle <= 1'b0;
      end else if (divCnt >= selSync) begin
         divCnt <= 2'h0;
         tickToggle <= ~tickToggle;
      end else begin
         divCnt <= divCnt + 2'h1;
      end
   end

endmodule // rdh_clk_div

/* test/rdh_i2c_master.sv */
// Serial bus master model standing in for the host controller
module rdh_i2c_master #(
   parameter int Q = 10
)(
   input wire logic sys_clk,
   input wire logic sdaLine,
   output logic scl,
   output logic sdaLow,
   output logic rdValid,
   output logic [7:0] rdData
);
   timeunit 1ns;
   timeprecision 1ns;
   // --------------------------------------------------------------
   // Bus primitives, all changes at the falling system edge
   // --------------------------------------------------------------
   initial begin
      scl = 1'b1; // Only the master drives the clock line
      sdaLow = 1'b0;
      rdValid = 1'b0;
      rdData = 8'h00;
   end
   task automatic waitQ();
      repeat (Q) @(negedge sys_clk);
   endtask
   // Also serves as repeated start: data falls while the clock is high
   task automatic start();
      sdaLow = 1'b0;
      waitQ();
      scl = 1'b1;
      waitQ();
      sdaLow = 1'b1;
      waitQ();
      scl = 1'b0;
      waitQ();
   endtask
   task automatic stop();
      sdaLow = 1'b1;
      waitQ();
      scl = 1'b1;
      waitQ();
      sdaLow = 1'b0;
      waitQ();
   endtask
   // Data set while the clock is low, so it never looks like start or stop
   task automatic clkBit(input logic d, output logic s);
      sdaLow = !d;
      waitQ();
      scl = 1'b1;
      waitQ();
      s = sdaLine;
      waitQ();
      scl = 1'b0;
      waitQ();
   endtask
   task automatic wrByte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) clkBit(b[i], s); // Whole bytes, MSB first
      clkBit(1'b1, ack);
   endtask
   // Last byte is refused by the master to end the read
   task automatic rdByte(input logic last);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clkBit(1'b1, s);
         rdData[i] = s;
      end
      rdValid = 1'b1; // One-cycle strobe, so each byte is checked once
      @(negedge sys_clk);
      rdValid = 1'b0;
      clkBit(last, s);
   endtask
endmodule // rdh_i2c_master

/* test/test_rdh_host_port.sv */
// Self-checking bench for the radio data host register port
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; \
   $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module test_rdh_host_port;
   import rdh_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [6:0] ADDR = 7'h11; // Same as the port's default SLAVE_ADDR
   logic sys_clk, reset, xtalClk, sdaOut, sdaOe, resultWe, latchReq, resultsReadyN, pauseOutN;
   logic scl, sdaLow, rdValid, ack, supplyLow;
   logic [7:0] rdData;
   logic [3:0] audioAbove;
   logic [31:0] rnd = 32'ha79f;
   rdh_result_s resultIn, resA, resB;
   rdh_ctrl_s ctrlOut, ctrlExp;
   int checked = 0;
   int fail_count = 0;
   int cycles = 0;
   logic [15:0] notes[$];
   wire sdaLine = (sdaOe ? sdaOut : 1'b1) & !sdaLow; // Pulled-up open-drain wire
   rdh_host_port #(.NOPAUSE_CNT(8), .DAV_CNT(400), .PMIN1_CNT(12),
      .STALL_CNT(64)) rdh_host_port_inst (.sys_clk(sys_clk),
      .reset(reset), .xtalClk(xtalClk), .supplyLow(supplyLow), .sclIn(scl), .sdaIn(sdaLine),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .audioAbove(audioAbove), .resultWe(resultWe),
      .resultIn(resultIn), .latchReq(latchReq), .ctrlOut(ctrlOut),
      .resultsReadyN(resultsReadyN), .pauseOutN(pauseOutN));
   rdh_i2c_master mst (.sys_clk(sys_clk), .sdaLine(sdaLine), .scl(scl),
      .sdaLow(sdaLow), .rdValid(rdValid), .rdData(rdData));
   // --------------------------------------------------------------
   // Clocks, timeout and read-data monitor
   // --------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   // Odd offset keeps the crystal edges clear of the system clock edges
   initial begin
      xtalClk = 1'b0;
      #37;
      forever #80 xtalClk = ~xtalClk;
   end
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 60000) begin
         fail_count++;
         close_out();
      end
   end
   // Oldest note holds mask and masked expected byte
   always @(posedge sys_clk) if (rdValid) begin
      `CHK("readByte", notes[0][7:0], rdData & notes[0][15:8])
      void'(notes.pop_front());
   end
   // --------------------------------------------------------------
   // Helpers
   // --------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      for (int i = 0; i < 32; i++) x = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
      return x;
   endfunction
   task automatic note(input logic [7:0] m, input logic [7:0] e);
      notes.push_back({m, e & m});
   endtask
   task automatic rdSeq(input int n);
      mst.start();
      mst.wrByte({ADDR, 1'b1}, ack);
      `CHK("readAddrAck", 1'b0, ack)
      for (int i = 0; i < n; i++) mst.rdByte(i == n - 1); // Pointer advances per byte
      mst.stop();
   endtask
   task automatic pulseWe(input rdh_result_s r);
      resultIn = r;
      resultWe = 1'b1;
      @(negedge sys_clk);
      resultWe = 1'b0;
   endtask
   task automatic randRes(output rdh_result_s r);
      logic [31:0] t;
      rnd = lfsr(rnd);
      t = rnd;
      rnd = lfsr(rnd);
      r = rdh_result_s'({t[23:0], rnd});
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // --------------------------------------------------------------
   // Main sequence
   // --------------------------------------------------------------
   initial begin
      reset = 1'b1;
      resultWe = 1'b0;
      latchReq = 1'b0;
      supplyLow = 1'b0;
      audioAbove = 4'hf; // Loud audio so no pause starts before setup
      resultIn = '0;
      repeat (4) @(negedge sys_clk);
      reset = 1'b0;
      @(negedge sys_clk);
      `CHK("ctrlDefault", 24'h000000, ctrlOut)
      `CHK("readyAfterReset", 1'b0, resultsReadyN)
      `CHK("pauseIdle", 1'b1, pauseOutN)
      note(8'h02, 8'h02); // Reset-seen flag up
      rdSeq(1);
      `CHK("readyAfterStatus", 1'b1, resultsReadyN)
      $display("test reset done");
      // Control bytes in the documented order, then one too many
      rnd = lfsr(rnd);
      ctrlExp = {rnd[7:0], 2'b10, rnd[13:8], 3'b011, rnd[20:16]}; // Time, n = 2
      mst.start();
      mst.wrByte({ADDR, 1'b0}, ack);
      `CHK("writeAddrAck", 1'b0, ack)
      for (int i = 2; i >= 0; i--) begin
         mst.wrByte(ctrlExp[i*8 +: 8], ack);
         `CHK("writeAck", 1'b0, ack)
      end
      mst.wrByte(8'h5a, ack);
      `CHK("extraByteNack", 1'b1, ack)
      mst.stop();
      `CHK("ctrlBeforeLatch", 24'h000000, ctrlOut)
      latchReq = 1'b1;
      @(negedge sys_clk);
      latchReq = 1'b0;
      `CHK("ctrlLatched", ctrlExp, ctrlOut)
      $display("test write done");
      // Unread block then a second one: overflow freezes the first
      randRes(resA);
      randRes(resB);
      pulseWe(resA);
      `CHK("readyOnResult", 1'b0, resultsReadyN)
      note(8'hff, {resA.status[7:2], 2'b00});
      rdSeq(1);
      pulseWe(resB);
      note(8'hff, {resA.status[7:2], 2'b01});
      for (int i = 5; i >= 0; i--) note(8'hff, resA[i*8 +: 8]);
      rdSeq(7); // New transfer restarts at the status byte
      pulseWe(resB);
      repeat (6000) @(negedge sys_clk);
      `CHK("readyHeld", 1'b0, resultsReadyN)
      for (int i = 0; i < 1000 && resultsReadyN !== 1'b1; i++) @(negedge sys_clk);
      `CHK("readyTimeout", 1'b1, resultsReadyN)
      $display("test results done");
      // Only the selected threshold counts
      audioAbove = 4'b0100;
      repeat (500) @(negedge sys_clk);
      `CHK("otherThreshIgnored", 1'b1, pauseOutN)
      audioAbove = 4'b1011;
      for (int i = 0; i < 2000 && pauseOutN !== 1'b0; i++) @(negedge sys_clk);
      `CHK("pauseDetected", 1'b0, pauseOutN)
      audioAbove = 4'b0100;
      repeat (20) @(negedge sys_clk);
      `CHK("pauseHeld", 1'b0, pauseOutN)
      for (int i = 0; i < 2000 && pauseOutN !== 1'b1; i++) @(negedge sys_clk);
      `CHK("pauseEnded", 1'b1, pauseOutN)
      $display("test pause done");
      supplyLow = 1'b1; // Supply drop acts as a reset
      repeat (4) @(negedge sys_clk);
      supplyLow = 1'b0;
      repeat (4) @(negedge sys_clk);
      `CHK("ctrlAfterDrop", 24'h000000, ctrlOut)
      `CHK("readyAfterDrop", 1'b0, resultsReadyN)
      note(8'h02, 8'h02);
      rdSeq(1);
      $display("test drop done");
      close_out();
   end
endmodule // test_rdh_host_port
